// ===== src/rhra_defs.vh
// rhra_defs.vh: constants of the RAM-DAC host register port.
// assumes inclusion by bare name from every design file of the block.
`ifndef RHRA_DEFS_VH
`define RHRA_DEFS_VH

// ----------------------------------------------------------------------
// select coding {select_high, select_low}
// ----------------------------------------------------------------------
`define RHRA_SEL_INDEX 2'h0
`define RHRA_SEL_PALETTE 2'h1
`define RHRA_SEL_CONTROL 2'h2
`define RHRA_SEL_MODE 2'h3

// ----------------------------------------------------------------------
// index values of the control registers
// ----------------------------------------------------------------------
`define RHRA_IDX_PIXEL_MASK 8'h04
`define RHRA_IDX_CALIBRATION 8'h05
`define RHRA_IDX_FORMAT_SYNC 8'h06
`define RHRA_IDX_MUX_CLOCK 8'h07

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RHRA_RST_BYTE 8'h00
`define RHRA_RST_WORD 10'h000
`define RHRA_RST_COUNT 4'h0
`define RHRA_RST_COLOUR 2'h0

// ----------------------------------------------------------------------
// primary mode register fields
// ----------------------------------------------------------------------
`define RHRA_MODE_PIPE_BIT 0
`define RHRA_MODE_WIDE_BIT 1
`define RHRA_MODE_LOAD_BIT 5
`define RHRA_PIPE_PATTERN 3'h5
`define RHRA_LOAD_PATTERN 3'h2

// ----------------------------------------------------------------------
// format/sync and mux/clock command fields
// ----------------------------------------------------------------------
`define RHRA_FMT_COLOUR_HI 7
`define RHRA_FMT_COLOUR_LO 5
`define RHRA_FMT_COLOUR_24 3'h7
`define RHRA_FMT_PEDESTAL_BIT 3
`define RHRA_FMT_SYNC_BIT 2
`define RHRA_MUX_RATIO_BIT 6
`define RHRA_DIV_HI_BIT 7
`define RHRA_DIV_LO_BIT 0
`define RHRA_DIV_BY2 2'h0
`define RHRA_DIV_BY8 2'h1
`define RHRA_DIV_BY4 2'h2
`define RHRA_DIV_BY16 2'h3

// ----------------------------------------------------------------------
// palette colour pointer and sizes
// ----------------------------------------------------------------------
`define RHRA_COL_RED 2'h0
`define RHRA_COL_GREEN 2'h1
`define RHRA_COL_BLUE 2'h2
`define RHRA_PAL_DEPTH 256
`define RHRA_PAL_LAST 255
`define RHRA_IDX_STEP 8'h01
`define RHRA_CNT_STEP 4'h1
`define RHRA_PAD2 2'h0

`endif

// ===== src/rhra_sync.v
// rhra_sync.v: two flip-flop synchroniser for pins from the host side.
// assumes the inputs are asynchronous to mclk; output is safe to use.
`include "rhra_defs.vh"
module rhra_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire mclk,
  input wire nrst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1 <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // rhra_sync

// ===== src/rhra_seqdet.v
// rhra_seqdet.v: watches one mode bit over successive mode writes.
// assumes sample_en is a one-cycle pulse per mode register write.
`include "rhra_defs.vh"
module rhra_seqdet #(
  parameter [2:0] PATTERN = 3'h0
) (
  input wire mclk,
  input wire nrst,
  input wire sample_en,
  input wire bit_in,
  output reg hit
);

  reg [1:0] history;
  // fills over the first two writes, so reset zeros never count as written values
  reg [1:0] filled;
  wire [2:0] next_history;

  // oldest write in the top bit
  assign next_history = {history, bit_in};

  // pulse when the last three written values form the pattern
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      history <= `RHRA_PAD2;
      filled <= `RHRA_PAD2;
      hit <= 1'b0;
    end
    else
    begin
      hit <= sample_en && filled[1] && (next_history == PATTERN);
      if (sample_en)
      begin
        history <= next_history[1:0];
        filled <= {filled[0], 1'b1};
      end
    end
  end

endmodule // rhra_seqdet

// ===== src/rhra_top.v
// rhra_top.v: host register and palette access of a video RAM-DAC.
// assumes host pins are asynchronous to mclk and strobes last > 3 mclk;
// pixel_index comes from logic on mclk.
`include "rhra_defs.vh"
module rhra_top (
  input wire mclk,
  input wire nrst,
  input wire host_strobe_n,
  input wire select_high,
  input wire select_low,
  input wire host_read,
  input wire [9:0] host_data_in,
  output reg [9:0] host_data_out,
  output wire host_data_oe,
  input wire [7:0] pixel_index,
  output reg [9:0] pixel_red,
  output reg [9:0] pixel_green,
  output reg [9:0] pixel_blue,
  output wire wide_bus_mode,
  output wire true_colour_24,
  output wire pedestal_on,
  output wire sync_on_green,
  output wire mux_two_to_one,
  output wire pipeline_restart,
  output wire load_resync,
  output reg divided_clock_out
);

  // ----------------------------------------------------------------------
  // host pin synchronisers
  // ----------------------------------------------------------------------
  wire strobe_n_s;
  wire [12:0] pins_s;
  wire sel_high_s;
  wire sel_low_s;
  wire read_s;
  wire [9:0] data_s;
  reg strobe_n_d;
  wire access_go;
  wire [1:0] sel_code;

  rhra_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b1)
  ) u_sync_strobe (
    .mclk(mclk),
    .nrst(nrst),
    .async_in(host_strobe_n),
    .sync_out(strobe_n_s)
  );

  rhra_sync #(
    .WIDTH(13),
    .RESET_VALUE(13'h0000)
  ) u_sync_pins (
    .mclk(mclk),
    .nrst(nrst),
    .async_in({select_high, select_low, host_read, host_data_in}),
    .sync_out(pins_s)
  );

  // split the synchronised bundle
  assign sel_high_s = pins_s[12];
  assign sel_low_s = pins_s[11];
  assign read_s = pins_s[10];
  assign data_s = pins_s[9:0];
  assign sel_code = {sel_high_s, sel_low_s};

  // strobe edge detect on the synchronised copy only
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      strobe_n_d <= 1'b1;
    end
    else
    begin
      strobe_n_d <= strobe_n_s;
    end
  end

  // one access per strobe, taken at its leading edge
  assign access_go = strobe_n_d && !strobe_n_s;
  // drive the bus only while a read strobe is held
  assign host_data_oe = !strobe_n_s && read_s;

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  reg [7:0] index_reg;
  reg [7:0] primary_mode_reg;
  reg [7:0] pixel_mask;
  reg [7:0] calibration_command_reg;
  reg [7:0] format_sync_command_reg;
  reg [7:0] mux_clock_command_reg;
  reg [1:0] colour_sel;
  reg [9:0] pal_red [0:`RHRA_PAL_LAST];
  reg [9:0] pal_green [0:`RHRA_PAL_LAST];
  reg [9:0] pal_blue [0:`RHRA_PAL_LAST];

  wire is_write;
  wire mode_write;
  wire [9:0] pal_wr_value;
  reg [9:0] pal_rd_raw;
  reg [9:0] next_data_out;
  reg [7:0] ctrl_rd_value;
  wire [7:0] next_index;
  wire [1:0] next_colour;

  assign is_write = access_go && !read_s;
  assign mode_write = is_write && (sel_code == `RHRA_SEL_MODE);

  // 09H keeps the wide bit clear: 8-bit bus and palette
  // 0FH sets the wide bit: 10-bit bus and palette
  assign wide_bus_mode = primary_mode_reg[`RHRA_MODE_WIDE_BIT];

  // narrow data lands in the top bits so the DAC range stays full scale
  assign pal_wr_value = wide_bus_mode ? data_s : {data_s[7:0], `RHRA_PAD2};

  // pointer steps after the blue entry, wraps FFH to 00H
  assign next_colour = (colour_sel == `RHRA_COL_BLUE) ? `RHRA_COL_RED : colour_sel + 2'h1;
  assign next_index = (colour_sel == `RHRA_COL_BLUE) ? index_reg + `RHRA_IDX_STEP : index_reg;

  // palette entry under the pointer
  always @*
  begin
    if (colour_sel == `RHRA_COL_RED)
      pal_rd_raw = pal_red[index_reg];
    else if (colour_sel == `RHRA_COL_GREEN)
      pal_rd_raw = pal_green[index_reg];
    else
      pal_rd_raw = pal_blue[index_reg];
  end

  // control register chosen by the index
  always @*
  begin
    if (index_reg == `RHRA_IDX_PIXEL_MASK)
      ctrl_rd_value = pixel_mask;
    else if (index_reg == `RHRA_IDX_CALIBRATION)
      ctrl_rd_value = calibration_command_reg;
    else if (index_reg == `RHRA_IDX_FORMAT_SYNC)
      ctrl_rd_value = format_sync_command_reg;
    else if (index_reg == `RHRA_IDX_MUX_CLOCK)
      ctrl_rd_value = mux_clock_command_reg;
    else
      ctrl_rd_value = `RHRA_RST_BYTE;
  end

  // read data for the selected target
  always @*
  begin
    if (sel_code == `RHRA_SEL_INDEX)
      next_data_out = {`RHRA_PAD2, index_reg};
    else if (sel_code == `RHRA_SEL_MODE)
      next_data_out = {`RHRA_PAD2, primary_mode_reg};
    else if (sel_code == `RHRA_SEL_CONTROL)
      next_data_out = {`RHRA_PAD2, ctrl_rd_value};
    else if (wide_bus_mode)
      next_data_out = pal_rd_raw;
    else
      next_data_out = {`RHRA_PAD2, pal_rd_raw[9:2]};
  end

  // ----------------------------------------------------------------------
  // register writes and pointer
  // ----------------------------------------------------------------------
  // registers clear at reset; the host must still program them all
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      index_reg <= `RHRA_RST_BYTE;
      colour_sel <= `RHRA_RST_COLOUR;
      primary_mode_reg <= `RHRA_RST_BYTE;
      pixel_mask <= `RHRA_RST_BYTE;
      calibration_command_reg <= `RHRA_RST_BYTE;
      format_sync_command_reg <= `RHRA_RST_BYTE;
      mux_clock_command_reg <= `RHRA_RST_BYTE;
      host_data_out <= `RHRA_RST_WORD;
    end
    else if (access_go)
    begin
      if (read_s)
      begin
        host_data_out <= next_data_out;
      end
      if (sel_code == `RHRA_SEL_INDEX)
      begin
        if (!read_s)
        begin
          // index load restarts the colour sequence at red
          index_reg <= data_s[7:0];
          colour_sel <= `RHRA_COL_RED;
        end
      end
      else if (sel_code == `RHRA_SEL_MODE)
      begin
        if (!read_s)
        begin
          primary_mode_reg <= data_s[7:0];
        end
      end
      else if (sel_code == `RHRA_SEL_CONTROL)
      begin
        if (!read_s)
        begin
          // mask write, FFH gives all ones
          if (index_reg == `RHRA_IDX_PIXEL_MASK)
            pixel_mask <= data_s[7:0];
          else if (index_reg == `RHRA_IDX_CALIBRATION)
            calibration_command_reg <= data_s[7:0];
          else if (index_reg == `RHRA_IDX_FORMAT_SYNC)
            format_sync_command_reg <= data_s[7:0];
          else if (index_reg == `RHRA_IDX_MUX_CLOCK)
            mux_clock_command_reg <= data_s[7:0];
        end
      end
      else
      begin
        // reads walk the palette the same way as writes
        colour_sel <= next_colour;
        index_reg <= next_index;
      end
    end
  end

  // red, green, blue in turn at the pointed location
  always @(posedge mclk)
  begin
    if (is_write && (sel_code == `RHRA_SEL_PALETTE))
    begin
      if (colour_sel == `RHRA_COL_RED)
        pal_red[index_reg] <= pal_wr_value;
      else if (colour_sel == `RHRA_COL_GREEN)
        pal_green[index_reg] <= pal_wr_value;
      else
        pal_blue[index_reg] <= pal_wr_value;
    end
  end

  // ----------------------------------------------------------------------
  // pixel-side lookup
  // ----------------------------------------------------------------------
  wire [7:0] masked_index;

  // mask gates the pixel index before lookup
  assign masked_index = pixel_index & pixel_mask;

  // palette has no reset; outputs follow one cycle after the index
  always @(posedge mclk)
  begin
    pixel_red <= pal_red[masked_index];
    pixel_green <= pal_green[masked_index];
    pixel_blue <= pal_blue[masked_index];
  end

  // ----------------------------------------------------------------------
  // mode register reset sequences
  // ----------------------------------------------------------------------
  // pipeline bit 1,0,1 over three mode writes
  rhra_seqdet #(
    .PATTERN(`RHRA_PIPE_PATTERN)
  ) u_pipe_seq (
    .mclk(mclk),
    .nrst(nrst),
    .sample_en(mode_write),
    .bit_in(data_s[`RHRA_MODE_PIPE_BIT]),
    .hit(pipeline_restart)
  );

  // load sync bit 0,1,0 over three mode writes
  rhra_seqdet #(
    .PATTERN(`RHRA_LOAD_PATTERN)
  ) u_load_seq (
    .mclk(mclk),
    .nrst(nrst),
    .sample_en(mode_write),
    .bit_in(data_s[`RHRA_MODE_LOAD_BIT]),
    .hit(load_resync)
  );

  // ----------------------------------------------------------------------
  // command decode and divided clock
  // ----------------------------------------------------------------------
  // ECH: 24-bit colour, pedestal, sync on green
  assign true_colour_24 = format_sync_command_reg[`RHRA_FMT_COLOUR_HI:`RHRA_FMT_COLOUR_LO] == `RHRA_FMT_COLOUR_24;
  assign pedestal_on = format_sync_command_reg[`RHRA_FMT_PEDESTAL_BIT];
  assign sync_on_green = format_sync_command_reg[`RHRA_FMT_SYNC_BIT];
  assign mux_two_to_one = mux_clock_command_reg[`RHRA_MUX_RATIO_BIT];

  reg [3:0] div_count;
  wire [3:0] next_div_count;
  wire [1:0] div_sel;
  reg next_div_out;

  // resync restarts the divider so the clock phase is known
  assign next_div_count = load_resync ? `RHRA_RST_COUNT : div_count + `RHRA_CNT_STEP;
  assign div_sel = {mux_clock_command_reg[`RHRA_DIV_HI_BIT], mux_clock_command_reg[`RHRA_DIV_LO_BIT]};

  // C0H selects clock divided by four
  always @*
  begin
    case (div_sel)
      `RHRA_DIV_BY2: next_div_out = next_div_count[0];
      `RHRA_DIV_BY4: next_div_out = next_div_count[1];
      `RHRA_DIV_BY8: next_div_out = next_div_count[2];
      default: next_div_out = next_div_count[3];
    endcase
  end

  // divider and registered clock output
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_count <= `RHRA_RST_COUNT;
      divided_clock_out <= 1'b0;
    end
    else
    begin
      div_count <= next_div_count;
      divided_clock_out <= next_div_out;
    end
  end

endmodule // rhra_top

// ===== test/rhra_top_assertions.sv
// rhra_top_assertions.sv: port-level checks on rhra_top.
// assumes host pins stay stable around each strobe, as the bench host does.
module rhra_chk (
  input wire mclk,
  input wire nrst,
  input wire host_strobe_n,
  input wire select_high,
  input wire select_low,
  input wire host_read,
  input wire [9:0] host_data_out,
  input wire host_data_oe,
  input wire wide_bus_mode,
  input wire true_colour_24,
  input wire pedestal_on,
  input wire mux_two_to_one,
  input wire pipeline_restart,
  input wire load_resync
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------------
  // read path: enable follows synced pins, data moves only under enable
  // ----------------------------------------------------------------------
  // enable timing
  AST_OE_FOLLOWS_PINS: assert property (@(posedge mclk) disable iff (!nrst)
    host_data_oe == (!$past(host_strobe_n, 2) && $past(host_read, 2))) else $error("read enable timing off");
  AST_DOUT_ONLY_ON_READ: assert property (@(posedge mclk) disable iff (!nrst)
    $changed(host_data_out) |-> $past(host_data_oe)) else $error("read data moved without a read");
  // ----------------------------------------------------------------------
  // mode sequences: single pulses, caused by mode writes only
  // ----------------------------------------------------------------------
  // one-cycle pulse
  AST_PIPE_PULSE: assert property (@(posedge mclk) disable iff (!nrst)
    pipeline_restart |=> !pipeline_restart) else $error("pipeline restart longer than one cycle");
  AST_PIPE_CAUSE: assert property (@(posedge mclk) disable iff (!nrst)
    pipeline_restart |-> $past(select_high, 4) && $past(select_low, 4) && !$past(host_read, 4))
    else $error("pipeline restart without mode write");
  AST_LOAD_PULSE: assert property (@(posedge mclk) disable iff (!nrst)
    load_resync |=> !load_resync) else $error("load resync longer than one cycle");
  AST_LOAD_CAUSE: assert property (@(posedge mclk) disable iff (!nrst)
    load_resync |-> $past(select_high, 4) && $past(select_low, 4) && !$past(host_read, 4))
    else $error("load resync without mode write");
  // ----------------------------------------------------------------------
  // decoded settings change only after the matching write
  // ----------------------------------------------------------------------
  // mode write for the bus width, control write for colour, pedestal and mux
  AST_WIDE_CAUSE: assert property (@(posedge mclk) disable iff (!nrst)
    $changed(wide_bus_mode) |-> $past(select_high, 4) && $past(select_low, 4) && !$past(host_read, 4))
    else $error("bus width changed without mode write");
  AST_COLOUR_CAUSE: assert property (@(posedge mclk) disable iff (!nrst)
    $changed(true_colour_24) |-> $past(select_high, 4) && !$past(select_low, 4) && !$past(host_read, 4))
    else $error("colour format changed without control write");
  AST_PEDESTAL_CAUSE: assert property (@(posedge mclk) disable iff (!nrst)
    $changed(pedestal_on) |-> $past(select_high, 4) && !$past(select_low, 4) && !$past(host_read, 4))
    else $error("pedestal changed without control write");
  AST_MUX_CAUSE: assert property (@(posedge mclk) disable iff (!nrst)
    $changed(mux_two_to_one) |-> $past(select_high, 4) && !$past(select_low, 4) && !$past(host_read, 4))
    else $error("mux ratio changed without control write");
endmodule // rhra_chk

bind rhra_top rhra_chk u_chk (.mclk(mclk), .nrst(nrst), .host_strobe_n(host_strobe_n),
  .select_high(select_high), .select_low(select_low), .host_read(host_read), .host_data_out(host_data_out),
  .host_data_oe(host_data_oe), .wide_bus_mode(wide_bus_mode), .true_colour_24(true_colour_24),
  .pedestal_on(pedestal_on), .mux_two_to_one(mux_two_to_one), .pipeline_restart(pipeline_restart),
  .load_resync(load_resync));

// ===== test/rhra_host.sv
// rhra_host.sv: host microprocessor model driving the register port pins.
// assumes mclk is free running; one access at a time through task access.
module rhra_host (
  input wire mclk,
  output logic host_strobe_n,
  output logic select_high,
  output logic select_low,
  output logic host_read,
  output logic [9:0] host_data_in,
  input wire [9:0] host_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle pins; strobe high so the synchroniser sees no access
  initial
  begin
    host_strobe_n = 1'b1;
    {select_high, select_low} = 2'h0;
    host_read = 1'b0;
    host_data_in = 10'h155;
  end
  // select coding
  // pins settle 4 cycles before the strobe and hold 4 after, beyond the 3 needed
  task automatic access(input logic [1:0] sel, input logic rd, input logic [9:0] d, output logic [9:0] q);
    @(posedge mclk);
    {select_high, select_low} <= sel;
    host_read <= rd;
    host_data_in <= rd ? ~host_data_in : d;
    repeat (4) @(posedge mclk);
    host_strobe_n <= 1'b0;
    repeat (6) @(posedge mclk);
    q = host_data_out;
    host_strobe_n <= 1'b1;
    repeat (4) @(posedge mclk);
    // bus released: no stale value left on it
    host_data_in <= ~host_data_in;
  endtask
endmodule // rhra_host

// ===== test/ramdac_host_register_access_tb.sv
// ramdac_host_register_access_tb.sv: self-checking bench of rhra_top.
// assumes the host model rhra_host and the bound checker are compiled first.
`include "rhra_defs.vh"
module ramdac_host_register_access_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] s_idx = `RHRA_SEL_INDEX;
  localparam logic [1:0] s_pal = `RHRA_SEL_PALETTE;
  localparam logic [1:0] s_ctl = `RHRA_SEL_CONTROL;
  localparam logic [1:0] s_mode = `RHRA_SEL_MODE;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] pixel_index = 8'h00;
  wire host_strobe_n, select_high, select_low, host_read, host_data_oe, divided_clock_out;
  wire wide_bus_mode, true_colour_24, pedestal_on, sync_on_green, mux_two_to_one;
  wire pipeline_restart, load_resync;
  wire [9:0] host_data_in, host_data_out, pixel_red, pixel_green, pixel_blue;
  int err_count = 0;
  int comparisons = 0;
  int n_pipe = 0;
  int n_load = 0;
  logic [7:0] ctl_idx [4] = '{8'h04, 8'h05, 8'h06, 8'h07};
  logic [7:0] ctl_val [4] = '{8'hFF, 8'h00, 8'hEC, 8'hC0};
  always #10 mclk = ~mclk;
  rhra_top uut (.mclk(mclk), .nrst(nrst), .host_strobe_n(host_strobe_n), .select_high(select_high),
    .select_low(select_low), .host_read(host_read), .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .pixel_index(pixel_index), .pixel_red(pixel_red), .pixel_green(pixel_green),
    .pixel_blue(pixel_blue), .wide_bus_mode(wide_bus_mode), .true_colour_24(true_colour_24),
    .pedestal_on(pedestal_on), .sync_on_green(sync_on_green), .mux_two_to_one(mux_two_to_one),
    .pipeline_restart(pipeline_restart), .load_resync(load_resync), .divided_clock_out(divided_clock_out));
  rhra_host host (.mclk(mclk), .host_strobe_n(host_strobe_n), .select_high(select_high),
    .select_low(select_low), .host_read(host_read), .host_data_in(host_data_in), .host_data_out(host_data_out));
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // pulse counters, so a double pulse also shows
  always @(posedge mclk)
  begin
    if (pipeline_restart === 1'b1) n_pipe++;
    if (load_resync === 1'b1) n_load++;
  end
  task chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [1:0] sel, input logic [9:0] d);
    logic [9:0] q;
    host.access(sel, 1'b0, d, q);
  endtask
  task rdc(input logic [1:0] sel, input logic [9:0] exp);
    logic [9:0] q;
    host.access(sel, 1'b1, 10'h000, q);
    chk(q, exp);
  endtask
  // one lookup latency plus margin before comparing
  task pix(input logic [7:0] idx, input logic [9:0] r, input logic [9:0] g, input logic [9:0] b);
    @(posedge mclk);
    pixel_index <= idx;
    repeat (3) @(posedge mclk);
    // look after the edge, once the outputs have settled
    #1;
    chk(pixel_red, r);
    chk(pixel_green, g);
    chk(pixel_blue, b);
  endtask
  // cycles between two rising edges of the divided clock
  task period(input logic [9:0] exp);
    int t0;
    int t1;
    logic prev;
    t0 = -1;
    t1 = -1;
    prev = 1'b1;
    for (int i = 0; i < 80; i++)
    begin
      @(posedge mclk);
      #1;
      if (divided_clock_out === 1'b1 && prev === 1'b0)
      begin
        if (t0 < 0) t0 = i;
        else if (t1 < 0) t1 = i;
      end
      prev = divided_clock_out;
    end
    chk(10'(t1 - t0), exp);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (5) @(posedge mclk);
    // mode toggles before any other programming
    wr(s_mode, 10'h009);
    wr(s_mode, 10'h008);
    wr(s_mode, 10'h009);
    chk(10'(n_pipe), 10'h001);
    chk(10'(n_load), 10'h000);
    wr(s_mode, 10'h029);
    wr(s_mode, 10'h009);
    chk(10'(n_pipe), 10'h001);
    chk(10'(n_load), 10'h001);
    rdc(s_mode, 10'h009);
    chk({9'h000, wide_bus_mode}, 10'h000);
    // control registers through the index, each read back
    for (int i = 0; i < 4; i++)
    begin
      wr(s_idx, {2'h0, ctl_idx[i]});
      wr(s_ctl, {2'h0, ctl_val[i]});
      rdc(s_ctl, {2'h0, ctl_val[i]});
    end
    chk({6'h00, true_colour_24, pedestal_on, sync_on_green, mux_two_to_one}, 10'h00F);
    period(10'h004);
    // unmapped index: write dropped, read zero, format/sync register at 06H untouched
    wr(s_idx, 10'h008);
    wr(s_ctl, 10'h05A);
    rdc(s_ctl, 10'h000);
    wr(s_idx, 10'h006);
    rdc(s_ctl, 10'h0EC);
    wr(s_idx, 10'h007);
    wr(s_ctl, 10'h041);
    period(10'h008);
    // palette in 8-bit mode: red, green, blue then next location
    wr(s_idx, 10'h000);
    for (int i = 0; i < 6; i++) wr(s_pal, 10'(8'h11 * (i + 1)));
    pix(8'h01, 10'h110, 10'h154, 10'h198);
    // last location wraps the pointer to location zero
    wr(s_idx, 10'h0FF);
    wr(s_pal, 10'h0A1);
    wr(s_pal, 10'h0A2);
    wr(s_pal, 10'h0A3);
    wr(s_pal, 10'h077);
    pix(8'hFF, 10'h284, 10'h288, 10'h28C);
    pix(8'h00, 10'h1DC, 10'h088, 10'h0CC);
    wr(s_idx, 10'h001);
    rdc(s_pal, 10'h044);
    // mask 01H folds every pixel index onto location zero or one
    wr(s_idx, 10'h004);
    wr(s_ctl, 10'h001);
    pix(8'hFE, 10'h1DC, 10'h088, 10'h0CC);
    pix(8'hFF, 10'h110, 10'h154, 10'h198);
    wr(s_ctl, 10'h0FF);
    // 10-bit mode keeps all ten bits of an entry
    wr(s_mode, 10'h00F);
    chk({9'h000, wide_bus_mode}, 10'h001);
    wr(s_idx, 10'h002);
    wr(s_pal, 10'h3FF);
    wr(s_pal, 10'h2A5);
    wr(s_pal, 10'h155);
    pix(8'h02, 10'h3FF, 10'h2A5, 10'h155);
    wr(s_idx, 10'h002);
    rdc(s_pal, 10'h3FF);
    conclude;
  end
  // watchdog: the sequence needs under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    conclude;
  end
endmodule // ramdac_host_register_access_tb
